// ==== rtl/autoneg_pkg.sv ====
// Function
// - exchange capabilities only when both ends support and enable negotiation
// - outgoing burst word comes from the local advertisement word
// - while negotiating send fast pulse bursts, each carrying the control word
// - store decoded partner capability word in the partner ability word
// - pick highest common technology, 100TX full down to 10T half
// - on completion set the completion bit and its detailed status copy
// - after completion enable the resolved technology, power down the rest
// - no burst answer from partner leads to parallel detection
// - parallel detection clears partner_negotiation_capable
// - parallel detection sets partner ability bit 5 or bit 7
// - parallel detection ends with completion set and technology enabled
// - only normal link pulses received means a 10T-only partner
// - scrambled 100M idles received means a 100TX partner without negotiation
// - partner answering with bursts sets partner_negotiation_capable
// - no receive signal during monitoring sets the no-signal bit
// - normal link pulses and 100M idles at once, with no burst word, set the detection fault bit
// - pulse signalling is the standard one, transparent to packet layers
// - parallel detection runs by itself with no station_manager action
// - any reset returns logic to idle and clears monitor status bits
// - restart on link failure after completion, restart request, or enable toggled off and on
`default_nettype none
package autoneg_pkg;

    localparam int ADV_W = 16;
    localparam int BIT_10HD = 5;
    localparam int BIT_10FD = 6;
    localparam int BIT_100HD = 7;
    localparam int BIT_100FD = 8;
    localparam int BIT_T4 = 9;
    localparam logic [ADV_W-1:0] ADV_RESET = 16'h0000;

    // response window while bursts go out
    localparam int RESP_WAIT_US = 50000;
    localparam int CLK_MHZ = 100;
    localparam int RESP_WAIT_CYC = RESP_WAIT_US * CLK_MHZ;

    // identical bursts needed before a partner word is accepted
    localparam logic [1:0] MATCH_COUNT = 2'h3;
    localparam logic [1:0] MATCH_FIRST = 2'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_TX_FLP = 3'h1,
        ST_ABILITY = 3'h2,
        ST_RESOLVE = 3'h3,
        ST_COMPLETE = 3'h4
    } an_state_t;

    typedef enum logic [2:0] {
        TECH_NONE = 3'h0,
        TECH_10HD = 3'h1,
        TECH_10FD = 3'h2,
        TECH_100HD = 3'h3,
        TECH_100FD = 3'h4
    } tech_t;

    typedef struct packed {
        logic en_100;
        logic en_10;
        logic full_duplex;
    } tech_en_t;

    typedef struct packed {
        logic complete;
        logic qp_complete;
        logic partner_negotiation_capable;
        logic pd_fault;
        logic no_signal;
    } an_status_t;

    localparam an_status_t STATUS_RESET = 5'h00;
    localparam tech_en_t TECH_EN_OFF = 3'h0;

endpackage
`default_nettype wire

// ==== rtl/link_autoneg_parallel_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module link_autoneg_parallel_detect
    import autoneg_pkg::*;
#(
    parameter int RESP_WAIT_CYCLES = RESP_WAIT_CYC
) (
    input wire logic CLK_SYS_IN, // system clock
    input wire logic RESET_N_IN, // async reset, active low
    input wire logic SOFT_RESET_IN, // software reset pulse
    input wire logic AN_ENABLE_IN, // negotiation enable level
    input wire logic AN_RESTART_IN, // restart request pulse
    input wire logic LINK_FAIL_IN, // link failure pulse
    input wire logic STATUS_READ_IN, // station_manager read of status
    input wire logic [ADV_W-1:0] ADV_WORD_IN, // local advertisement word
    input wire tech_t FORCE_TECH_IN, // technology when negotiation off
    input wire logic FLP_WORD_VALID_IN, // burst word decoded
    input wire logic [ADV_W-1:0] FLP_WORD_IN, // decoded burst word
    input wire logic NLP_SEEN_IN, // normal link pulse seen
    input wire logic IDLE100_SEEN_IN, // scrambled 100M idle seen
    input wire logic RX_ENERGY_IN, // receive signal present, pin
    output logic TX_FLP_OUT, // send bursts instead of pulses
    output logic [ADV_W-1:0] TX_WORD_OUT, // word carried by bursts
    output logic [ADV_W-1:0] LP_ABILITY_OUT, // partner ability word
    output an_status_t STATUS_OUT, // negotiation status bits
    output tech_en_t TECH_EN_OUT // technology enables
);

    localparam int TW = $clog2(RESP_WAIT_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(RESP_WAIT_CYCLES - 1);
    localparam logic [TW-1:0] TIMER_ZERO = '0;

    function automatic tech_t resolve(input logic [ADV_W-1:0] a, input logic [ADV_W-1:0] b);
        logic [ADV_W-1:0] c;
        c = a & b;
        // the T4 slot is skipped: not supported here
        if (c[BIT_100FD]) begin
            return TECH_100FD;
        end else if (c[BIT_100HD]) begin
            return TECH_100HD;
        end else if (c[BIT_10FD]) begin
            return TECH_10FD;
        end else if (c[BIT_10HD]) begin
            return TECH_10HD;
        end
        return TECH_NONE;
    endfunction

    function automatic tech_en_t enables(input tech_t t);
        tech_en_t e;
        e.en_100 = (t == TECH_100FD) || (t == TECH_100HD);
        e.en_10 = (t == TECH_10FD) || (t == TECH_10HD);
        e.full_duplex = (t == TECH_100FD) || (t == TECH_10FD);
        return e;
    endfunction

    // ***************************************************************
    // receive energy synchroniser
    // ***************************************************************
    logic sync1_q, sync2_q, sync3_q, energy_q, energy_d;

    always_comb begin
        energy_d = energy_q;
        if (sync2_q == sync3_q) begin
            energy_d = sync3_q;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            energy_q <= 1'b0;
        end else begin
            sync1_q <= RX_ENERGY_IN;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            energy_q <= energy_d;
        end
    end

    // ***************************************************************
    // arbitration and progress monitor
    // ***************************************************************
    an_state_t st_q, st_d;
    tech_t tech_q, tech_d;
    an_status_t status_q, status_d;
    tech_en_t tech_en_q, tech_en_d;
    logic [ADV_W-1:0] adv_q, adv_d, lp_q, lp_d, last_q, last_d;
    logic [TW-1:0] timer_q, timer_d;
    logic [1:0] match_q, match_d;
    logic en_prev_q, flp_q, flp_d, restart;

    assign restart = (AN_ENABLE_IN && !en_prev_q) || AN_RESTART_IN
                     || (LINK_FAIL_IN && st_q == ST_COMPLETE);

    always_comb begin
        st_d = st_q;
        tech_d = tech_q;
        status_d = status_q;
        adv_d = adv_q;
        lp_d = lp_q;
        last_d = last_q;
        timer_d = timer_q;
        match_d = match_q;
        if (STATUS_READ_IN) begin
            status_d.pd_fault = 1'b0;
            status_d.no_signal = 1'b0;
        end
        if (SOFT_RESET_IN) begin
            st_d = ST_IDLE;
            status_d = STATUS_RESET;
            tech_d = TECH_NONE;
            lp_d = ADV_RESET;
            timer_d = TIMER_ZERO;
            match_d = 2'h0;
        end else if (!AN_ENABLE_IN) begin
            st_d = ST_IDLE;
            tech_d = FORCE_TECH_IN;
            status_d.complete = 1'b0;
            status_d.qp_complete = 1'b0;
        end else if (restart || st_q == ST_IDLE) begin
            // monitor bits survive a restart
            st_d = ST_TX_FLP;
            adv_d = ADV_WORD_IN;
            tech_d = TECH_NONE;
            status_d.complete = 1'b0;
            status_d.qp_complete = 1'b0;
            timer_d = TIMER_ZERO;
            match_d = 2'h0;
        end else begin
            case (st_q)
                ST_TX_FLP: begin
                    timer_d = timer_q + 1'b1;
                    if (FLP_WORD_VALID_IN) begin
                        status_d.partner_negotiation_capable = 1'b1;
                        last_d = FLP_WORD_IN;
                        match_d = MATCH_FIRST;
                        timer_d = TIMER_ZERO;
                        st_d = ST_ABILITY;
                    end else if (NLP_SEEN_IN && IDLE100_SEEN_IN) begin
                        status_d.pd_fault = 1'b1;
                    end else if (NLP_SEEN_IN || IDLE100_SEEN_IN) begin
                        status_d.partner_negotiation_capable = 1'b0;
                        if (NLP_SEEN_IN) begin
                            lp_d[BIT_10HD] = 1'b1;
                            tech_d = TECH_10HD;
                        end else begin
                            lp_d[BIT_100HD] = 1'b1;
                            tech_d = TECH_100HD;
                        end
                        status_d.complete = 1'b1;
                        status_d.qp_complete = 1'b1;
                        st_d = ST_COMPLETE;
                    end else if (timer_q == TIMER_LAST) begin
                        timer_d = TIMER_ZERO;
                        if (!energy_q) begin
                            status_d.no_signal = 1'b1;
                        end
                    end
                end
                ST_ABILITY: begin
                    timer_d = timer_q + 1'b1;
                    if (FLP_WORD_VALID_IN) begin
                        timer_d = TIMER_ZERO;
                        last_d = FLP_WORD_IN;
                        if (FLP_WORD_IN != last_q) begin
                            match_d = MATCH_FIRST;
                        end else if (match_q + 1'b1 == MATCH_COUNT) begin
                            lp_d = FLP_WORD_IN;
                            st_d = ST_RESOLVE;
                        end else begin
                            match_d = match_q + 1'b1;
                        end
                    end else if (timer_q == TIMER_LAST) begin
                        timer_d = TIMER_ZERO;
                        st_d = ST_TX_FLP;
                    end
                end
                ST_RESOLVE: begin
                    tech_d = resolve(adv_q, lp_q);
                    if (tech_d == TECH_NONE) begin
                        st_d = ST_TX_FLP;
                    end else begin
                        status_d.complete = 1'b1;
                        status_d.qp_complete = 1'b1;
                        st_d = ST_COMPLETE;
                    end
                end
                ST_COMPLETE: begin
                    st_d = ST_COMPLETE;
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
        flp_d = (st_d == ST_TX_FLP) || (st_d == ST_ABILITY);
        tech_en_d = (st_d == ST_COMPLETE || !AN_ENABLE_IN) ? enables(tech_d) : TECH_EN_OFF;
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            st_q <= ST_IDLE;
            tech_q <= TECH_NONE;
            status_q <= STATUS_RESET;
            tech_en_q <= TECH_EN_OFF;
            adv_q <= ADV_RESET;
            lp_q <= ADV_RESET;
            last_q <= ADV_RESET;
            timer_q <= TIMER_ZERO;
            match_q <= 2'h0;
            en_prev_q <= 1'b0;
            flp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tech_q <= tech_d;
            status_q <= status_d;
            tech_en_q <= tech_en_d;
            adv_q <= adv_d;
            lp_q <= lp_d;
            last_q <= last_d;
            timer_q <= timer_d;
            match_q <= match_d;
            en_prev_q <= AN_ENABLE_IN;
            flp_q <= flp_d;
        end
    end

    assign TX_FLP_OUT = flp_q;
    assign TX_WORD_OUT = adv_q;
    assign LP_ABILITY_OUT = lp_q;
    assign STATUS_OUT = status_q;
    assign TECH_EN_OUT = tech_en_q;

    // ***************************************************************
    // checks
    // ***************************************************************
    logic calm;
    assign calm = AN_ENABLE_IN && !SOFT_RESET_IN && !restart;

    a_flp_sets_capable: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        calm && st_q == ST_TX_FLP && FLP_WORD_VALID_IN
        |=> STATUS_OUT.partner_negotiation_capable && st_q == ST_ABILITY)
        else $error("partner burst did not mark partner capable");

    a_nlp_picks_10t: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        calm && st_q == ST_TX_FLP && !FLP_WORD_VALID_IN && NLP_SEEN_IN && !IDLE100_SEEN_IN
        |=> tech_q == TECH_10HD && LP_ABILITY_OUT[BIT_10HD]
            && !STATUS_OUT.partner_negotiation_capable && STATUS_OUT.complete)
        else $error("link pulses did not select 10T");

    a_idle_picks_100: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        calm && st_q == ST_TX_FLP && !FLP_WORD_VALID_IN && !NLP_SEEN_IN && IDLE100_SEEN_IN
        |=> tech_q == TECH_100HD && LP_ABILITY_OUT[BIT_100HD]
            && TECH_EN_OUT.en_100 && !TECH_EN_OUT.en_10)
        else $error("100M idles did not select 100TX");

    a_multi_sets_fault: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        calm && st_q == ST_TX_FLP && !FLP_WORD_VALID_IN && NLP_SEEN_IN && IDLE100_SEEN_IN
        |=> STATUS_OUT.pd_fault && !STATUS_OUT.complete)
        else $error("mixed indications did not set fault");

    a_complete_copies: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        st_q == ST_COMPLETE |-> STATUS_OUT.complete && STATUS_OUT.qp_complete)
        else $error("completion bits disagree");

    a_tech_enabled: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        st_q == ST_COMPLETE && AN_ENABLE_IN |-> TECH_EN_OUT == enables(tech_q))
        else $error("resolved technology not enabled alone");

    a_resolve_prio: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        calm && st_q == ST_RESOLVE && resolve(adv_q, lp_q) != TECH_NONE
        |=> tech_q == resolve($past(adv_q), $past(lp_q)) && st_q == ST_COMPLETE)
        else $error("wrong common technology chosen");

    a_no_common_back: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        calm && st_q == ST_RESOLVE && resolve(adv_q, lp_q) == TECH_NONE
        |=> st_q == ST_TX_FLP && TX_FLP_OUT && !STATUS_OUT.complete)
        else $error("no common technology did not resume bursts");

    a_silence_flags: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        calm && st_q == ST_TX_FLP && !FLP_WORD_VALID_IN && !NLP_SEEN_IN && !IDLE100_SEEN_IN
            && timer_q == TIMER_LAST && !energy_q
        |=> STATUS_OUT.no_signal)
        else $error("silent line did not set the no-signal bit");

    a_soft_reset_idle: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        SOFT_RESET_IN |=> st_q == ST_IDLE && STATUS_OUT == STATUS_RESET)
        else $error("software reset left state or status");

    a_restart_path: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        AN_ENABLE_IN && !SOFT_RESET_IN && restart
        |=> st_q == ST_TX_FLP && TX_FLP_OUT && !STATUS_OUT.complete
            && TX_WORD_OUT == $past(ADV_WORD_IN))
        else $error("restart did not reopen the burst exchange");

    a_off_no_bursts: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        !AN_ENABLE_IN |=> !TX_FLP_OUT && st_q == ST_IDLE)
        else $error("bursts sent with negotiation disabled");

endmodule // link_autoneg_parallel_detect
`default_nettype wire

// ==== verif/link_partner_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// remote partner answering the burst exchange
// ****************************************
module link_partner_model
    import autoneg_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic go_in, // start one answer
    input wire logic [2:0] mode_in, // 0 none 1 bursts 2 pulses 3 idles 4 mixed
    input wire logic [ADV_W-1:0] word_in, // capability word to send
    input wire logic [3:0] gap_in, // cycles before answering
    output logic flp_valid_out, // burst word decoded
    output logic [ADV_W-1:0] flp_word_out, // decoded burst word
    output logic nlp_out, // normal link pulse seen
    output logic idle_out, // scrambled idle seen
    output logic energy_out // receive signal present
);
    initial begin
        flp_valid_out = 1'h0;
        flp_word_out = 16'hFFFF;
        nlp_out = 1'h0;
        idle_out = 1'h0;
        energy_out = 1'h0;
        forever begin
            @(posedge clk_in);
            if (go_in === 1'h1) begin
                energy_out <= (mode_in != 3'h0);
                repeat (gap_in) @(posedge clk_in);
                if (mode_in == 3'h1) begin
                    // between bursts the word is stale, so show its inverse
                    repeat (3) begin
                        flp_valid_out <= 1'h1;
                        flp_word_out <= word_in;
                        @(posedge clk_in);
                        flp_valid_out <= 1'h0;
                        flp_word_out <= ~word_in;
                        @(posedge clk_in);
                    end
                end else if (mode_in != 3'h0) begin
                    nlp_out <= (mode_in != 3'h3);
                    idle_out <= (mode_in != 3'h2);
                    @(posedge clk_in);
                    nlp_out <= 1'h0;
                    idle_out <= 1'h0;
                end
            end
        end
    end
endmodule // link_partner_model
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
    import autoneg_pkg::*;
;
    // ****************************************
    // stimulus, partner and checks
    // ****************************************
    localparam int WAIT_CYC = 20;
    localparam int LIMIT = 2000;
    localparam int P_SOFT = 0, P_RESTART = 1, P_FAIL = 2, P_READ = 3, P_GO = 4;
    typedef struct packed {
        logic [15:0] adv;
        logic [2:0] mode;
        logic [15:0] word;
        logic [3:0] gap;
        tech_en_t tech;
        logic [15:0] lp;
        logic cap;
    } row_t;
    row_t rows [6] = '{
        '{16'h01E0, 3'h1, 16'h01E0, 4'h0, 3'h5, 16'h01E0, 1'h1},
        '{16'h01E0, 3'h1, 16'h0060, 4'h5, 3'h3, 16'h0060, 1'h1},
        '{16'h00A0, 3'h1, 16'h0180, 4'h2, 3'h4, 16'h0180, 1'h1},
        '{16'h0220, 3'h1, 16'h0220, 4'h0, 3'h2, 16'h0220, 1'h1},
        '{16'h01E0, 3'h2, 16'h0000, 4'h3, 3'h2, 16'h0020, 1'h0},
        '{16'h01E0, 3'h3, 16'h0000, 4'h0, 3'h4, 16'h0080, 1'h0}};
    logic clk_sys, reset_n, an_enable, flp_valid, nlp_seen, idle_seen, rx_energy, tx_flp, go;
    logic [4:0] pulses;
    logic [ADV_W-1:0] adv_word, flp_word, tx_word, lp_ability, p_word;
    logic [2:0] mode;
    logic [3:0] gap;
    tech_t force_tech;
    an_status_t status;
    tech_en_t tech_en;
    int n_fail, compares, cycles;

    link_autoneg_parallel_detect #(.RESP_WAIT_CYCLES(WAIT_CYC)) link_autoneg_parallel_detect_i (
        .CLK_SYS_IN(clk_sys), .RESET_N_IN(reset_n), .SOFT_RESET_IN(pulses[P_SOFT]),
        .AN_ENABLE_IN(an_enable), .AN_RESTART_IN(pulses[P_RESTART]),
        .LINK_FAIL_IN(pulses[P_FAIL]), .STATUS_READ_IN(pulses[P_READ]),
        .ADV_WORD_IN(adv_word), .FORCE_TECH_IN(force_tech), .FLP_WORD_VALID_IN(flp_valid),
        .FLP_WORD_IN(flp_word), .NLP_SEEN_IN(nlp_seen), .IDLE100_SEEN_IN(idle_seen),
        .RX_ENERGY_IN(rx_energy), .TX_FLP_OUT(tx_flp), .TX_WORD_OUT(tx_word),
        .LP_ABILITY_OUT(lp_ability), .STATUS_OUT(status), .TECH_EN_OUT(tech_en));
    link_partner_model link_partner_model_i (
        .clk_in(clk_sys), .go_in(pulses[P_GO]), .mode_in(mode), .word_in(p_word),
        .gap_in(gap), .flp_valid_out(flp_valid), .flp_word_out(flp_word),
        .nlp_out(nlp_seen), .idle_out(idle_seen), .energy_out(rx_energy));

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    task tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task note(input logic ok, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (ok !== 1'h1) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_word(input logic [15:0] got, input logic [15:0] exp);
        note(got === exp, got, exp);
    endtask
    task cmp_status(input an_status_t got, input an_status_t exp);
        note(got === exp, 16'(got), 16'(exp));
    endtask
    task cmp_tech(input tech_en_t got, input tech_en_t exp);
        note(got === exp, 16'(got), 16'(exp));
    endtask
    task cmp_bit(input logic got, input logic exp);
        note(got === exp, 16'(got), 16'(exp));
    endtask

    task pulse(input int sel);
        @(posedge clk_sys);
        pulses[sel] <= 1'h1;
        @(posedge clk_sys);
        pulses[sel] <= 1'h0;
    endtask

    // soft reset, let the exchange start, then the partner answers
    task run_row(input int i);
        int k;
        @(posedge clk_sys);
        adv_word <= rows[i].adv;
        mode <= rows[i].mode;
        p_word <= rows[i].word;
        gap <= rows[i].gap;
        pulse(P_SOFT);
        repeat (3) @(posedge clk_sys);
        pulse(P_GO);
        k = 0;
        @(negedge clk_sys);
        while (status.complete !== 1'h1 && k < 60) begin
            @(negedge clk_sys);
            k++;
        end
    endtask

    initial begin
        reset_n = 1'h0;
        pulses = 5'h00;
        an_enable = 1'h1;
        adv_word = 16'h01E0;
        force_tech = TECH_NONE;
        mode = 3'h0;
        p_word = 16'h0000;
        gap = 4'h0;
        n_fail = 0;
        compares = 0;
        cycles = 0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        cmp_status(status, STATUS_RESET);
        cmp_tech(tech_en, TECH_EN_OFF);
        cmp_word(lp_ability, 16'h0000);
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'h1;
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            run_row(i);
            @(negedge clk_sys);
            cmp_status(status, an_status_t'{1'h1, 1'h1, rows[i].cap, 1'h0, 1'h0});
            cmp_tech(tech_en, rows[i].tech);
            cmp_word(lp_ability, rows[i].lp);
            cmp_word(tx_word, rows[i].adv);
            cmp_bit(tx_flp, 1'h0);
            $display("test row %0d done", i);
        end
        run_row(0);
        pulse(P_RESTART);
        @(negedge clk_sys);
        cmp_bit(tx_flp, 1'h1);
        cmp_bit(status.complete, 1'h0);
        cmp_bit(status.partner_negotiation_capable, 1'h1);
        cmp_tech(tech_en, TECH_EN_OFF);
        run_row(1);
        pulse(P_FAIL);
        @(negedge clk_sys);
        cmp_bit(tx_flp, 1'h1);
        cmp_bit(status.complete, 1'h0);
        run_row(2);
        pulse(P_SOFT);
        @(negedge clk_sys);
        cmp_status(status, STATUS_RESET);
        cmp_word(lp_ability, 16'h0000);
        cmp_tech(tech_en, TECH_EN_OFF);
        $display("test restart done");
        @(posedge clk_sys);
        an_enable <= 1'h0;
        force_tech <= TECH_10FD;
        mode <= 3'h1;
        gap <= 4'h0;
        pulse(P_GO);
        repeat (10) @(negedge clk_sys);
        cmp_status(status, STATUS_RESET);
        cmp_tech(tech_en, 3'h3);
        cmp_bit(tx_flp, 1'h0);
        @(posedge clk_sys);
        an_enable <= 1'h1;
        mode <= 3'h4;
        @(posedge clk_sys);
        @(negedge clk_sys);
        cmp_bit(tx_flp, 1'h1);
        $display("test enable done");
        pulse(P_SOFT);
        repeat (3) @(posedge clk_sys);
        pulse(P_GO);
        repeat (4) @(negedge clk_sys);
        cmp_status(status, an_status_t'{1'h0, 1'h0, 1'h0, 1'h1, 1'h0});
        cmp_bit(tx_flp, 1'h1);
        pulse(P_READ);
        @(negedge clk_sys);
        cmp_bit(status.pd_fault, 1'h0);
        $display("test fault done");
        mode <= 3'h0;
        pulse(P_GO);
        repeat (50) @(negedge clk_sys);
        cmp_bit(status.no_signal, 1'h1);
        cmp_bit(status.complete, 1'h0);
        cmp_bit(tx_flp, 1'h1);
        $display("test silence done");
        mode <= 3'h1;
        p_word <= 16'h0040;
        pulse(P_GO);
        repeat (8) @(negedge clk_sys);
        cmp_word(lp_ability, 16'h0040);
        cmp_bit(status.complete, 1'h0);
        cmp_bit(tx_flp, 1'h1);
        $display("test no common done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
